// ### logic/fppf_pkg.sv
// Constants shared by the four-port pin-function logic
`default_nettype none
package fppf_pkg;
	localparam int          PORT_W        = 8;
	// Port 3 secondary-function bit positions
	localparam int          P3_RXD_BIT    = 0;
	localparam int          P3_TXD_BIT    = 1;
	localparam int          P3_IRQ0_BIT   = 2;
	localparam int          P3_IRQ1_BIT   = 3;
	localparam int          P3_CNT0_BIT   = 4;
	localparam int          P3_CNT1_BIT   = 5;
	localparam int          P3_WR_BIT     = 6;
	localparam int          P3_RD_BIT     = 7;
	// Address latch strobe rate: one pulse per six oscillator periods
	localparam int          ALE_DIV       = 6;
	localparam logic [2:0]  ALE_LAST      = 3'h5;
	localparam logic [2:0]  ALE_ZERO      = 3'h0;
	localparam logic [7:0]  LATCH_RST     = 8'hff;
	localparam logic [7:0]  BYTE_ZERO     = 8'h00;
	localparam logic [7:0]  BYTE_ONES     = 8'hff;
endpackage
`default_nettype wire

// ### logic/fppf_top.sv
// Pin-function logic for the four parallel ports
`default_nettype none
// Summary of operation
// - Port 0 is open-drain I/O, multiplexing low address and data on bus cycles.
// - During program verification port 0 drives read-back program data.
// - Port 1 is quasi-bidirectional; programmer supplies low address in verify.
// - Port 2 is quasi-bidirectional and drives high address on external access.
// - Port 3 is bidirectional with pull-ups and dedicated special functions.
// - Port 3 bits 0,1 serial in/out; bits 2,3 external interrupts.
// - Port 3 bits 4,5 counter inputs; bits 6,7 active-low write/read strobes.
// - Port 3 special function works only while its latch holds one.
// - Address latch strobe every six clocks, one skipped per data access.
module fppf_top
	import fppf_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	// Core side: port latches and write strobes
	input  wire logic [7:0]  i_p0_latch_d,
	input  wire logic        i_p0_latch_we,
	input  wire logic [7:0]  i_p1_latch_d,
	input  wire logic        i_p1_latch_we,
	input  wire logic [7:0]  i_p2_latch_d,
	input  wire logic        i_p2_latch_we,
	input  wire logic [7:0]  i_p3_latch_d,
	input  wire logic        i_p3_latch_we,
	// Core side: external bus controls
	input  wire logic        i_ext_bus,
	input  wire logic        i_bus_addr_phase,
	input  wire logic        i_bus_drive_data,
	input  wire logic [15:0] i_bus_addr,
	input  wire logic [7:0]  i_bus_wdata,
	input  wire logic        i_xdata_access,
	input  wire logic        i_xdata_wr_n,
	input  wire logic        i_xdata_rd_n,
	input  wire logic        i_serial_tx,
	// Program verification
	input  wire logic        i_verify,
	input  wire logic [7:0]  i_verify_data,
	// Pins
	input  wire logic [7:0]  i_p0_pin,
	output logic      [7:0]  o_p0_pin,
	output logic      [7:0]  o_p0_oe,
	input  wire logic [7:0]  i_p1_pin,
	output logic      [7:0]  o_p1_pin,
	output logic      [7:0]  o_p1_oe,
	output logic      [7:0]  o_p1_pullup,
	input  wire logic [7:0]  i_p2_pin,
	output logic      [7:0]  o_p2_pin,
	output logic      [7:0]  o_p2_oe,
	output logic      [7:0]  o_p2_pullup,
	input  wire logic [7:0]  i_p3_pin,
	output logic      [7:0]  o_p3_pin,
	output logic      [7:0]  o_p3_oe,
	output logic      [7:0]  o_p3_pullup,
	output logic             o_ale,
	// Synchronised pin reads and special-function inputs to the core
	output logic      [7:0]  o_p0_in,
	output logic      [7:0]  o_p1_in,
	output logic      [7:0]  o_p2_in,
	output logic      [7:0]  o_p3_in,
	output logic             o_serial_rx,
	output logic             o_ext_irq_zero_in,
	output logic             o_ext_irq_one_in,
	output logic             o_counter_zero_input,
	output logic             o_counter_one_input
);

	// ---------------------------------------------------------------
	// Port latches
	// ---------------------------------------------------------------
	logic [7:0] p0_latch_q;
	logic [7:0] p1_latch_q;
	logic [7:0] p2_latch_q;
	logic [7:0] p3_latch_q;

	// Latches reset to all ones so quasi pins start as inputs
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			p0_latch_q <= LATCH_RST;
			p1_latch_q <= LATCH_RST;
			p2_latch_q <= LATCH_RST;
			p3_latch_q <= LATCH_RST;
		end
		else
		begin
			if (i_p0_latch_we)
				p0_latch_q <= i_p0_latch_d;
			if (i_p1_latch_we)
				p1_latch_q <= i_p1_latch_d;
			if (i_p2_latch_we)
				p2_latch_q <= i_p2_latch_d;
			if (i_p3_latch_we)
				p3_latch_q <= i_p3_latch_d;
		end
	end

	// ---------------------------------------------------------------
	// Pin input synchronisers
	// ---------------------------------------------------------------
	logic [31:0] pin_s1_q;
	logic [31:0] pin_s2_q;

	// Two flops on every pin before any logic sees it
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			pin_s1_q <= {4{BYTE_ONES}};
			pin_s2_q <= {4{BYTE_ONES}};
		end
		else
		begin
			pin_s1_q <= {i_p3_pin, i_p2_pin, i_p1_pin, i_p0_pin};
			pin_s2_q <= pin_s1_q;
		end
	end

	assign o_p0_in = pin_s2_q[7:0];
	assign o_p1_in = pin_s2_q[15:8]; // Verify low address arrives here
	assign o_p2_in = pin_s2_q[23:16]; // Verify high address/controls
	assign o_p3_in = pin_s2_q[31:24];

	// Special inputs pass only while the latch bit is one
	assign o_serial_rx = pin_s2_q[24 + P3_RXD_BIT]
		& p3_latch_q[P3_RXD_BIT];
	assign o_ext_irq_zero_in = pin_s2_q[24 + P3_IRQ0_BIT]
		& p3_latch_q[P3_IRQ0_BIT];
	assign o_ext_irq_one_in = pin_s2_q[24 + P3_IRQ1_BIT]
		& p3_latch_q[P3_IRQ1_BIT];
	assign o_counter_zero_input = pin_s2_q[24 + P3_CNT0_BIT]
		& p3_latch_q[P3_CNT0_BIT];
	assign o_counter_one_input = pin_s2_q[24 + P3_CNT1_BIT]
		& p3_latch_q[P3_CNT1_BIT];

	// ---------------------------------------------------------------
	// Port drivers
	// ---------------------------------------------------------------
	logic [7:0] p0_out_d;
	logic [7:0] p0_oe_d;
	logic [7:0] p2_out_d;
	logic [7:0] p3_fn_d;
	logic [7:0] p0_out_q;
	logic [7:0] p0_oe_q;
	logic [7:0] p1_out_q;
	logic [7:0] p2_out_q;
	logic [7:0] p3_out_q;

	// Port 0 source selection
	always_comb
	begin
		if (i_verify)
		begin
			p0_out_d = i_verify_data;
			p0_oe_d  = BYTE_ONES;
		end
		else if (i_ext_bus && i_bus_addr_phase)
		begin
			p0_out_d = i_bus_addr[7:0];
			p0_oe_d  = BYTE_ONES;
		end
		else if (i_ext_bus && i_bus_drive_data)
		begin
			p0_out_d = i_bus_wdata;
			p0_oe_d  = BYTE_ONES;
		end
		else if (i_ext_bus)
		begin
			p0_out_d = BYTE_ZERO; // Bus read: float
			p0_oe_d  = BYTE_ZERO;
		end
		else
		begin
			p0_out_d = BYTE_ZERO; // Open drain: sink zeros only
			p0_oe_d  = ~p0_latch_q;
		end
	end

	// Port 2 emits high address during external cycles
	assign p2_out_d = i_ext_bus ? i_bus_addr[15:8] : p2_latch_q;

	// Port 3 function outputs ANDed with latch
	always_comb
	begin
		p3_fn_d = p3_latch_q;
		p3_fn_d[P3_TXD_BIT] = p3_latch_q[P3_TXD_BIT] & i_serial_tx;
		p3_fn_d[P3_WR_BIT]  = p3_latch_q[P3_WR_BIT] & i_xdata_wr_n;
		p3_fn_d[P3_RD_BIT]  = p3_latch_q[P3_RD_BIT] & i_xdata_rd_n;
	end

	// Output registers for all pin data
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			p0_out_q <= BYTE_ZERO;
			p0_oe_q  <= BYTE_ZERO;
			p1_out_q <= LATCH_RST;
			p2_out_q <= LATCH_RST;
			p3_out_q <= LATCH_RST;
		end
		else
		begin
			p0_out_q <= p0_out_d;
			p0_oe_q  <= p0_oe_d;
			p1_out_q <= p1_latch_q;
			p2_out_q <= p2_out_d;
			p3_out_q <= p3_fn_d;
		end
	end

	// Quasi pins: drive only zeros hard, weak pull-up on ones
	assign o_p0_pin    = p0_out_q;
	assign o_p0_oe     = p0_oe_q;
	assign o_p1_pin    = p1_out_q;
	assign o_p1_oe     = ~p1_out_q;
	assign o_p1_pullup = p1_out_q;
	assign o_p2_pin    = p2_out_q;
	assign o_p2_oe     = ~p2_out_q;
	assign o_p2_pullup = p2_out_q;
	assign o_p3_pin    = p3_out_q;
	assign o_p3_oe     = ~p3_out_q; // Low forces pin
	assign o_p3_pullup = p3_out_q;

	// ---------------------------------------------------------------
	// Address latch strobe
	// ---------------------------------------------------------------
	logic [2:0] ale_cnt_q;
	logic       ale_skip_q;
	logic       ale_q;

	// Divide by six; one pulse dropped per external data access
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			ale_cnt_q  <= ALE_ZERO;
			ale_skip_q <= 1'b0;
			ale_q      <= 1'b0;
		end
		else
		begin
			ale_cnt_q <= (ale_cnt_q == ALE_LAST) ? ALE_ZERO
				: ale_cnt_q + 3'h1;
			if (ale_cnt_q == ALE_LAST)
			begin
				ale_q      <= !(ale_skip_q || i_xdata_access);
				ale_skip_q <= 1'b0;
			end
			else
			begin
				ale_q <= 1'b0;
				if (i_xdata_access)
					ale_skip_q <= 1'b1;
			end
		end
	end

	assign o_ale = ale_q;

endmodule
`default_nettype wire

// ### verification/fppf_chk_sva.sv
// Checker for the four-port pin-function outputs
`default_nettype none
module fppf_chk (
	input wire logic        i_ref_clk,
	input wire logic        i_rst_n,
	input wire logic        i_verify,
	input wire logic [7:0]  i_verify_data,
	input wire logic        i_bus_addr_phase,
	input wire logic [15:0] i_bus_addr,
	input wire logic        i_ext_bus,
	input wire logic        i_serial_tx,
	input wire logic        i_xdata_access,
	input wire logic        i_p1_latch_we,
	input wire logic [7:0]  i_p1_latch_d,
	input wire logic        i_p3_latch_we,
	input wire logic [7:0]  i_p3_latch_d,
	input wire logic [7:0]  o_p0_pin,
	input wire logic [7:0]  o_p1_pin,
	input wire logic [7:0]  o_p1_oe,
	input wire logic [7:0]  o_p2_pin,
	input wire logic [7:0]  o_p3_pin,
	input wire logic        o_ale,
	input wire logic [7:0]  o_p3_in,
	input wire logic        o_ext_irq_zero_in
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// Six strobe-period cycles with no data access
	sequence s_quiet; !i_xdata_access [*6]; endsequence
	property p_vfy; i_verify |=> o_p0_pin == $past(i_verify_data); endproperty
	a_vfy: assert property (p_vfy)
		else $error("verify byte not on port 0");
	property p_lo; i_ext_bus && i_bus_addr_phase && !i_verify
		|=> o_p0_pin == $past(i_bus_addr[7:0]); endproperty
	a_lo: assert property (p_lo)
		else $error("low address not on port 0");
	property p_hi; i_ext_bus |=> o_p2_pin == $past(i_bus_addr[15:8]);
	endproperty
	a_hi: assert property (p_hi)
		else $error("high address not on port 2");
	// Latch write reaches port 1 two edges later, ones never driven hard
	property p_oe; i_p1_latch_we |=> ##1 o_p1_pin == $past(i_p1_latch_d, 2)
		&& o_p1_oe == ~o_p1_pin; endproperty
	a_oe: assert property (p_oe)
		else $error("port 1 drives a one hard");
	property p_tx; o_p3_pin[1] && $past(i_rst_n) |-> $past(i_serial_tx);
	endproperty
	a_tx: assert property (p_tx)
		else $error("serial out high without source");
	property p_irq; o_ext_irq_zero_in |-> o_p3_in[2]; endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt input without pin");
	// A zero written to the latch blocks the interrupt input next cycle
	property p_gate; i_p3_latch_we && !i_p3_latch_d[2]
		|=> !o_ext_irq_zero_in; endproperty
	a_gate: assert property (p_gate)
		else $error("interrupt input not blocked by latch");
	property p_run; o_ale ##0 s_quiet ##1 1'b1 |-> o_ale; endproperty
	a_run: assert property (p_run)
		else $error("strobe missing after quiet period");
	property p_skip; o_ale && i_xdata_access |-> ##6 !o_ale; endproperty
	a_skip: assert property (p_skip)
		else $error("strobe not skipped on data access");
endmodule
bind fppf_top fppf_chk fppf_chk_inst (.*);
`default_nettype wire

// ### verification/fppf_pin_mdl.sv
// Pin model: device, outside driver and pull-up on one port
`default_nettype none
module fppf_pin_mdl (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_dev,
	input  wire logic [7:0] i_oe,
	input  wire logic [7:0] i_pu,
	input  wire logic [7:0] i_ext,
	input  wire logic [7:0] i_ext_en,
	output logic      [7:0] o_wire
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] flt_q = 8'h00;
	// Undriven lines wander every cycle
	always_ff @(posedge i_clk) flt_q <= ~flt_q;
	// Device first, then outside driver, then pull-up
	assign o_wire = i_oe & i_dev | ~i_oe & (i_ext_en & i_ext
		| ~i_ext_en & (i_pu | flt_q));
endmodule
`default_nettype wire

// ### verification/fppf_top_tb.sv
// Testbench for the four-port pin-function logic
`default_nettype none
module fppf_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_ref_clk, i_rst_n, i_ext_bus, i_bus_addr_phase, i_bus_drive_data;
	logic i_xdata_access, i_xdata_wr_n, i_xdata_rd_n, i_serial_tx, i_verify;
	logic i_p0_latch_we, i_p1_latch_we, i_p2_latch_we, i_p3_latch_we, o_ale;
	logic [7:0] i_p0_latch_d, i_p1_latch_d, i_p2_latch_d, i_p3_latch_d;
	logic [7:0] i_bus_wdata, i_verify_data, i_p0_pin, i_p1_pin, i_p2_pin;
	logic [7:0] i_p3_pin, o_p0_pin, o_p0_oe, o_p1_pin, o_p1_oe, o_p1_pullup;
	logic [7:0] o_p2_pin, o_p2_oe, o_p2_pullup, o_p3_pin, o_p3_oe, o_p3_pullup;
	logic [7:0] o_p0_in, o_p1_in, o_p2_in, o_p3_in, x1, x2, x3, e1, e2, e3;
	logic [15:0] i_bus_addr;
	logic o_serial_rx, o_ext_irq_zero_in, o_ext_irq_one_in;
	logic o_counter_zero_input, o_counter_one_input;
	int failures, n_compared;
	fppf_top fppf_top_inst (.*);
	fppf_pin_mdl fppf_pin_mdl_inst0 (.i_clk(i_ref_clk), .i_dev(o_p0_pin),
		.i_oe(o_p0_oe), .i_pu(8'h00), .i_ext(8'h00), .i_ext_en(8'h00),
		.o_wire(i_p0_pin));
	fppf_pin_mdl fppf_pin_mdl_inst1 (.i_clk(i_ref_clk), .i_dev(o_p1_pin),
		.i_oe(o_p1_oe), .i_pu(o_p1_pullup), .i_ext(x1), .i_ext_en(e1),
		.o_wire(i_p1_pin));
	fppf_pin_mdl fppf_pin_mdl_inst2 (.i_clk(i_ref_clk), .i_dev(o_p2_pin),
		.i_oe(o_p2_oe), .i_pu(o_p2_pullup), .i_ext(x2), .i_ext_en(e2),
		.o_wire(i_p2_pin));
	fppf_pin_mdl fppf_pin_mdl_inst3 (.i_clk(i_ref_clk), .i_dev(o_p3_pin),
		.i_oe(o_p3_oe), .i_pu(o_p3_pullup), .i_ext(x3), .i_ext_en(e3),
		.o_wire(i_p3_pin));
	// Clock, 10 ns period
	initial
	begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	// Step past edges, then drive
	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// Verdict and stop
	task automatic end_sim;
		if (failures == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Bus address, data, then verify with programmer on ports 1 and 2
	task automatic t_bus;
		{i_ext_bus, i_bus_addr_phase, i_bus_drive_data} = 3'h7;
		{i_bus_addr, i_bus_wdata} = 24'ha55a_3c;
		tick(1);
		chk({o_p0_oe, o_p0_pin}, 16'hff5a);
		chk({o_p2_oe, o_p2_pin}, 16'h5aa5);
		chk(16'(o_p2_pullup), 16'h00a5);
		i_bus_addr_phase = 1'b0;
		tick(1);
		chk(16'(o_p0_pin), 16'h003c);
		{i_ext_bus, i_verify, i_verify_data, x1, x2} = 26'h1_c334_12;
		{i_bus_addr_phase, e1} = 9'h1ff;
		e2 = 8'hff;
		tick(1);
		chk(16'(o_p0_pin), 16'h00c3);
		tick(2);
		chk({o_p1_in, o_p2_in}, 16'h3412);
		chk(16'(o_p0_in), 16'h00c3);
		{i_verify, i_bus_addr_phase, i_bus_drive_data, e1, e2} = '0;
	endtask
	// Quasi port 1 and open-drain port 0 as plain I/O
	task automatic t_quasi;
		{x1, e1, i_p1_latch_d, i_p0_latch_d} = 32'h0fff_55f0;
		{i_p1_latch_we, i_p0_latch_we} = 2'h3;
		tick(1);
		{i_p1_latch_we, i_p0_latch_we} = 2'h0;
		tick(1);
		chk({o_p1_pin, o_p1_oe}, 16'h55aa);
		chk({o_p0_oe, o_p0_pin}, 16'h0f00);
		tick(2);
		chk(16'(o_p1_in), 16'h0005);
	endtask
	// Port 3 special functions, then gated off by a zero latch
	task automatic t_p3;
		{i_serial_tx, i_xdata_wr_n, i_xdata_rd_n, x3, e3} = 19'h1_0005;
		tick(1);
		chk(16'(o_p3_pin[7:6]), 16'h0002);
		chk(16'(o_p3_pin[1]), 16'h0000);
		chk({o_p3_oe, o_p3_pullup}, 16'h42bd);
		tick(1);
		chk(16'({o_serial_rx, o_ext_irq_zero_in}), 16'h0000);
		chk(16'(o_p3_in), 16'h00fa);
		chk(16'(o_ext_irq_one_in), 16'h0001);
		chk(16'(o_counter_zero_input), 16'h0001);
		chk(16'(o_counter_one_input), 16'h0001);
		{i_serial_tx, i_xdata_wr_n, e3, i_p3_latch_we} = 11'h601;
		tick(1);
		// Pins still read high here, so only the latch gate holds these low
		chk(16'(o_ext_irq_one_in), 16'h0000);
		chk(16'(o_counter_zero_input), 16'h0000);
		i_p3_latch_we = 1'b0;
		tick(1);
		chk(16'(o_p3_pin), 16'h0000);
		tick(2);
		chk(16'(o_ext_irq_one_in), 16'h0000);
		chk(16'(o_counter_zero_input), 16'h0000);
	endtask
	// Address strobe rate and the skipped pulse
	task automatic t_ale;
		for (int i = 0; i < 8 && o_ale !== 1'b1; i++)
			tick(1);
		if (o_ale !== 1'b1)
		begin
			failures++;
			end_sim();
		end
		tick(6);
		chk(16'(o_ale), 16'h0001);
		i_xdata_access = 1'b1;
		tick(1);
		i_xdata_access = 1'b0;
		tick(5);
		chk(16'(o_ale), 16'h0000);
		tick(6);
		chk(16'(o_ale), 16'h0001);
	endtask
	// Main sequence
	initial
	begin
		{i_rst_n, i_ext_bus, i_bus_addr_phase, i_bus_drive_data} = '0;
		{i_xdata_access, i_verify, i_bus_addr, i_bus_wdata} = '0;
		{i_p0_latch_we, i_p1_latch_we, i_p2_latch_we, i_p3_latch_we} = '0;
		{i_p0_latch_d, i_p1_latch_d, i_p2_latch_d, i_p3_latch_d} = '0;
		{i_verify_data, x1, x2, x3, e1, e2, e3} = '0;
		{i_xdata_wr_n, i_xdata_rd_n, i_serial_tx} = '1;
		{failures, n_compared} = '0;
		tick(3);
		i_rst_n = 1'b1;
		chk({o_p0_oe, o_p1_pullup}, 16'h00ff);
		chk(16'(o_ale), 16'h0000);
		t_bus();
		t_quasi();
		t_p3();
		t_ale();
		end_sim();
	end
endmodule
`default_nettype wire
